// ---- hdl/clock_reset_entry.v ----
/*
 clock and reset entry of the hub: takes the host differential clock, the 66 MHz
 hub reference and the 48 MHz display reference, qualifies the reset input with
 power good, and hands each domain a synchronously released reset. assumes the
 clocks arrive on dedicated clock ports and the pad ring resolves the enables.
 the negative host leg is not read, the pair is received single ended, and the
 domain resets are brought back into clock_i through three flops for the outputs.
*/
// What this block does
// - reset input clears all logic asynchronously
// - interface pads float while reset asserted
// - 66 MHz reference clocks graphics, hub link
// - 48 MHz reference feeds display PLL
// - differential host clock drives host logic
`timescale 1ns/100ps
`include "clock_reset_entry_defs.vh"
module clock_reset_entry (
	input wire clock_i,
	input wire arst_n_i,
	input wire system_reset_in_n_i,
	input wire power_good_in_i,
	input wire host_clock_pos_i,
	input wire host_clock_neg_i,
	input wire hub_ref_clock_66_i,
	input wire display_ref_clock_48_i,
	input wire [`CRE_PAD_W-1:0] pad_out_i,
	input wire [`CRE_PAD_W-1:0] pad_oe_i,
	output reg [`CRE_PAD_W-1:0] pad_out_o,
	output reg [`CRE_PAD_W-1:0] pad_oe_o,
	output reg host_rst_n_o,
	output reg hub_rst_n_o,
	output reg display_rst_n_o,
	output reg display_pll_ref_o,
	output reg core_ready_o
);
	// release sequence states
	localparam [1:0] st_held = 2'h0;
	localparam [1:0] st_wait = 2'h1;
	localparam [1:0] st_run = 2'h2;

	wire reset_any_n;
	reg rst_meta_q;
	reg rst_sync_q;
	reg pg_meta_q;
	reg pg_sync_q;
	reg disp_meta_q;
	reg disp_sync_q;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [`CRE_CNT_W-1:0] cnt_q;
	reg [`CRE_CNT_W-1:0] cnt_d;
	reg release_q;
	wire host_rst_n;
	wire hub_rst_n;
	wire disp_rst_n;

	// domain resets seen in clock_i
	wire host_seen_n;
	wire hub_seen_n;
	wire disp_seen_n;

	assign reset_any_n = arst_n_i & system_reset_in_n_i;

	// double flop of reset pin before use
	always @(posedge clock_i or negedge reset_any_n) begin
		if (!reset_any_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= system_reset_in_n_i;
			rst_sync_q <= rst_meta_q;
		end
	end

	// power good through two flops
	always @(posedge clock_i or negedge reset_any_n) begin
		if (!reset_any_n) begin
			pg_meta_q <= 1'b0;
			pg_sync_q <= 1'b0;
		end else begin
			pg_meta_q <= power_good_in_i;
			pg_sync_q <= pg_meta_q;
		end
	end

	// display reference through two flops
	always @(posedge clock_i or negedge reset_any_n) begin
		if (!reset_any_n) begin
			disp_meta_q <= 1'b0;
			disp_sync_q <= 1'b0;
		end else begin
			disp_meta_q <= display_ref_clock_48_i;
			disp_sync_q <= disp_meta_q;
		end
	end

	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			st_held: begin
				cnt_d = {`CRE_CNT_W{1'b0}};
				if (rst_sync_q && pg_sync_q) begin
					state_d = st_wait;
				end
			end
			st_wait: begin
				if (!rst_sync_q || !pg_sync_q) begin
					state_d = st_held;
				end else if (cnt_q == `CRE_HOLD_CYC - 1) begin
					state_d = st_run;
				end else begin
					cnt_d = cnt_q + 8'h01;
				end
			end
			st_run: begin
				if (!pg_sync_q) begin
					state_d = st_held;
				end
			end
			default: begin
				state_d = st_held;
			end
		endcase
	end

	// state, counter and release flops
	always @(posedge clock_i or negedge reset_any_n) begin
		if (!reset_any_n) begin
			state_q <= st_held;
			cnt_q <= {`CRE_CNT_W{1'b0}};
			release_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			release_q <= (state_d == st_run);
		end
	end

	reset_release_sync u_host_sync (
		.clk_i(host_clock_pos_i),
		.arst_n_i(reset_any_n),
		.release_i(release_q),
		.rst_n_o(host_rst_n)
	);

	// hub and graphics on 66 MHz
	reset_release_sync u_hub_sync (
		.clk_i(hub_ref_clock_66_i),
		.arst_n_i(reset_any_n),
		.release_i(release_q),
		.rst_n_o(hub_rst_n)
	);

	reset_release_sync u_disp_sync (
		.clk_i(display_ref_clock_48_i),
		.arst_n_i(reset_any_n),
		.release_i(release_q),
		.rst_n_o(disp_rst_n)
	);

	// host domain reset into clock_i
	reset_release_sync u_host_seen (
		.clk_i(clock_i),
		.arst_n_i(reset_any_n),
		.release_i(host_rst_n),
		.rst_n_o(host_seen_n)
	);

	// hub domain reset into clock_i
	reset_release_sync u_hub_seen (
		.clk_i(clock_i),
		.arst_n_i(reset_any_n),
		.release_i(hub_rst_n),
		.rst_n_o(hub_seen_n)
	);

	// display domain reset into clock_i
	reset_release_sync u_disp_seen (
		.clk_i(clock_i),
		.arst_n_i(reset_any_n),
		.release_i(disp_rst_n),
		.rst_n_o(disp_seen_n)
	);

	// registered pad group
	always @(posedge clock_i or negedge reset_any_n) begin
		if (!reset_any_n) begin
			pad_out_o <= {`CRE_PAD_W{1'b0}};
			pad_oe_o <= {`CRE_PAD_W{1'b0}};
		end else begin
			pad_out_o <= pad_out_i;
			pad_oe_o <= release_q ? pad_oe_i : {`CRE_PAD_W{1'b0}};
		end
	end

	// registered status outputs
	always @(posedge clock_i or negedge reset_any_n) begin
		if (!reset_any_n) begin
			host_rst_n_o <= 1'b0;
			hub_rst_n_o <= 1'b0;
			display_rst_n_o <= 1'b0;
			display_pll_ref_o <= 1'b0;
			core_ready_o <= 1'b0;
		end else begin
			host_rst_n_o <= host_seen_n;
			hub_rst_n_o <= hub_seen_n;
			display_rst_n_o <= disp_seen_n;
			display_pll_ref_o <= disp_sync_q;
			core_ready_o <= release_q;
		end
	end
endmodule // clock_reset_entry

// ---- hdl/clock_reset_entry_defs.vh ----
/*
 constants for the clock and reset entry block: synchroniser depth, timing
 figures and derived cycle counts. assumes a 20 MHz core clock on clock_i.
*/
`ifndef CLOCK_RESET_ENTRY_DEFS_VH
`define CLOCK_RESET_ENTRY_DEFS_VH
`define CRE_CLK_HZ 20000000
`define CRE_SYNC_STAGES 2
`define CRE_STABLE_US 10
`define CRE_STABLE_CYC ((`CRE_STABLE_US * `CRE_CLK_HZ + 999999) / 1000000)
`define CRE_HOLD_CYC 4
`define CRE_CNT_W 8
`define CRE_REF_HUB_MHZ 66
`define CRE_REF_DISP_MHZ 48
`define CRE_PAD_W 8
`endif

// ---- hdl/reset_release_sync.v ----
/*
 reset synchroniser: asynchronous assert, release on clock edges after the
 request drops. assumes clk_i is running during release.
*/
`timescale 1ns/100ps
module reset_release_sync (
	input wire clk_i,
	input wire arst_n_i,
	input wire release_i,
	output reg rst_n_o
);
	reg meta_q;

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_q <= 1'b0;
			rst_n_o <= 1'b0;
		end else begin
			meta_q <= release_i;
			rst_n_o <= meta_q;
		end
	end
endmodule // reset_release_sync

// ---- test/clk_synth.sv ----
/* clock source model: host clock and two references.
 assumes free running clocks. */
`timescale 1ns/100ps
module clk_synth (
	output logic hp_o = 1'b0,
	output logic hb_o = 1'b0,
	output logic dc_o = 1'b0
);
	always #5 hp_o = ~hp_o;
	always #7.6 hb_o = ~hb_o;
	always #10.4 dc_o = ~dc_o;
endmodule // clk_synth

// ---- test/clock_reset_entry_bench.sv ----
/* bench with random pad enables.
 assumes clk_synth and cre_chk. */
`timescale 1ns/100ps
module clock_reset_entry_bench;
	logic ck = 1'b0, ar = 1'b0, sr = 1'b1, pg = 1'b0;
	logic [7:0] pe = 8'h00, x;
	logic [2:0] dq = 3'h0;
	wire [7:0] oe, po;
	wire hp, hb, dc, h, g, d, r, pr;
	wire [7:0] st = {4'h0, r, h, g, d};
	integer err_total = 0, n_tests = 0, seed = 32'h4261;
	initial forever #25 ck = ~ck;
	// display reference seen through three clock_i flops
	always @(posedge ck) dq <= {dq[1:0], dc};
	clk_synth clk_synth_i (.hp_o(hp), .hb_o(hb), .dc_o(dc));
	clock_reset_entry clock_reset_entry_i (.clock_i(ck), .arst_n_i(ar), .system_reset_in_n_i(sr),
		.power_good_in_i(pg), .host_clock_pos_i(hp), .host_clock_neg_i(~hp), .hub_ref_clock_66_i(hb),
		.display_ref_clock_48_i(dc), .pad_out_i(pe), .pad_oe_i(pe), .pad_out_o(po), .pad_oe_o(oe),
		.host_rst_n_o(h), .hub_rst_n_o(g), .display_rst_n_o(d), .display_pll_ref_o(pr), .core_ready_o(r));
	task chk(input logic [7:0] s, e, input string n);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task final_report;
		if (err_total == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#60000;
		err_total++;
		final_report;
	end
	initial begin
		repeat (4) @(posedge ck);
		ar <= 1'b1;
		repeat (200) @(posedge ck);
		pg <= 1'b1;
		repeat (7) @(posedge ck);
		@(negedge ck) chk(st, 8'h00, "early");
		@(posedge ck);
		@(negedge ck) chk(st, 8'h08, "ready");
		repeat (10) @(posedge ck);
		@(negedge ck) chk(st, 8'h0F, "up");
		repeat (9) begin
			@(posedge ck);
			x = 8'($random(seed));
			pe <= x;
			@(posedge ck);
			@(negedge ck) chk(oe, x, "oe");
			chk(po, x, "out");
			chk({7'h00, pr}, {7'h00, dq[2]}, "pll ref");
		end
		@(posedge ck);
		pg <= 1'b0;
		repeat (10) @(posedge ck);
		@(negedge ck) chk(st | oe, 8'h00, "pg low");
		@(posedge ck);
		pg <= 1'b1;
		repeat (7) @(posedge ck);
		@(negedge ck) chk(st, 8'h00, "pg early");
		repeat (11) @(posedge ck);
		@(negedge ck) chk(st, 8'h0F, "pg up");
		@(posedge ck);
		sr <= 1'b0;
		@(negedge ck) chk(st | oe | po, 8'h00, "reset");
		@(posedge ck);
		sr <= 1'b1;
		repeat (7) @(posedge ck);
		@(negedge ck) chk(st, 8'h00, "rel early");
		repeat (11) @(posedge ck);
		@(negedge ck) chk(st, 8'h0F, "rel up");
		final_report;
	end
endmodule // clock_reset_entry_bench

// ---- test/cre_chk_assertions.sv ----
/* checks on clock_reset_entry ports.
 assumes clock_i samples, arst_n_i resets. */
`timescale 1ns/100ps
module cre_chk (
	input clock_i,
	input arst_n_i,
	input system_reset_in_n_i,
	input power_good_in_i,
	input [7:0] pad_oe_o,
	input host_rst_n_o,
	input hub_rst_n_o,
	input display_rst_n_o,
	input core_ready_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	rst_clr_a: assert property (!system_reset_in_n_i |->
		!core_ready_o && !host_rst_n_o && !hub_rst_n_o && !display_rst_n_o) else $error("not cleared");
	pad_off_a: assert property (!system_reset_in_n_i |-> pad_oe_o == 8'h00) else $error("pads on");
	hub_late_a: assert property ($rose(hub_rst_n_o) |-> core_ready_o) else $error("hub early");
	disp_late_a: assert property ($rose(display_rst_n_o) |-> core_ready_o) else $error("disp early");
	host_late_a: assert property ($rose(host_rst_n_o) |-> core_ready_o) else $error("host early");
	ready_qual_a: assert property ($rose(core_ready_o) |->
		($past(system_reset_in_n_i, 8) && $past(power_good_in_i, 8))) else $error("early");
	pg_drop_a: assert property ($fell(power_good_in_i) |->
		##[1:4] (!core_ready_o && pad_oe_o == 8'h00)) else $error("pg drop");
endmodule // cre_chk
bind clock_reset_entry cre_chk cre_chk_i (.*);
